// File: hdl/epc_pkg.sv
// Constants and types for the entropy polling register block
// Assumes a single system clock and a synchronous reset
package epc_pkg;
  localparam logic [11:0] EPC_CSR_ADDR   = 12'h015;
  localparam int          EPC_XLEN       = 64;
  localparam int          EPC_WORD_W     = 32;
  localparam int          EPC_ENT_W      = 16;
  localparam int          EPC_ST_HI      = 31;
  localparam int          EPC_ST_LO      = 30;
  localparam logic [1:0]  EPC_CODE_TEST  = 2'h0;
  localparam logic [1:0]  EPC_CODE_WAIT  = 2'h1;
  localparam logic [1:0]  EPC_CODE_READY = 2'h2;
  localparam logic [1:0]  EPC_CODE_DEAD  = 2'h3;
  localparam logic [5:0]  EPC_RSVD_VAL   = 6'h00;
  localparam logic [7:0]  EPC_CUSTOM_VAL = 8'h00;
  localparam logic [1:0]  EPC_PRIV_U     = 2'h0;
  localparam logic [1:0]  EPC_PRIV_S     = 2'h1;
  localparam logic [1:0]  EPC_PRIV_M     = 2'h3;
  localparam logic [1:0]  EPC_OP_RW      = 2'h1;
  localparam logic [1:0]  EPC_OP_RS      = 2'h2;
  localparam logic [1:0]  EPC_OP_RC      = 2'h3;
  localparam logic [15:0] EPC_WORD_RST   = 16'h0000;
  localparam logic [31:0] EPC_RDATA_RST  = 32'h00000000;

  typedef enum logic [3:0] {
    EPC_ST_SELF_TEST = 4'h1,
    EPC_ST_WAIT      = 4'h2,
    EPC_ST_READY     = 4'h4,
    EPC_ST_DEAD      = 4'h8
  } epc_state_type;
endpackage

// File: hdl/epc_word_if.sv
// Link between the poll register and its one-word entropy holder
// Assumes both ends run on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface epc_word_if;
  logic        enable;
  logic        take;
  logic        wipe;
  logic        full;
  logic        load;
  logic [15:0] word;
  modport holder (input enable, input take, input wipe, output full, output load, output word);
  modport user   (output enable, output take, output wipe, input full, input load, input word);
endinterface
`default_nettype wire

// File: hdl/epc_access_check.sv
// Privilege and instruction-form check for an access to the poll register
// Assumes the core presents mode, grant bits and op form in one cycle
`timescale 1ns/1ps
`default_nettype none
module epc_access_check
  import epc_pkg::*;
(
  // Access description
  input  wire logic [1:0] priv_mode,
  input  wire logic       virt_mode,
  input  wire logic [1:0] op_kind,
  input  wire logic       src_is_zero,
  // Grants from the machine security configuration
  input  wire logic       grant_super,
  input  wire logic       grant_user,
  // Verdict
  output logic            allow,
  output logic            illegal,
  output logic            virt_trap
);
  logic rw_form;

  always_comb begin
    rw_form   = (op_kind == EPC_OP_RW) ||
                (((op_kind == EPC_OP_RS) || (op_kind == EPC_OP_RC)) && !src_is_zero);
    allow     = 1'b0;
    illegal   = 1'b0;
    virt_trap = 1'b0;
    if (virt_mode) begin
      // Guest modes always trap; only a granted read-write form may be emulated
      virt_trap = rw_form && grant_super;
      illegal   = !virt_trap;
    end else begin
      case (priv_mode)
        EPC_PRIV_M: allow = rw_form;
        EPC_PRIV_S: allow = rw_form && grant_super;
        EPC_PRIV_U: allow = rw_form && grant_user;
        default:    allow = 1'b0;
      endcase
      illegal = !allow;
    end
  end
endmodule
`default_nettype wire

// File: hdl/epc_word_hold.sv
// One-word holder between the noise source and the poll register
// Assumes the source keeps valid and word steady until accepted
`timescale 1ns/1ps
`default_nettype none
module epc_word_hold
  import epc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Noise source side
  input  wire logic        src_valid,
  input  wire logic [15:0] src_word,
  output logic             src_ready,
  // Register side
  epc_word_if.holder       hold
);
  typedef struct packed {
    logic        full;
    logic [15:0] word;
  } epc_hold_type;

  epc_hold_type r_reg;
  epc_hold_type r_next;

  // A wipe blocks loading so an alarm never keeps a word
  assign src_ready = hold.enable && !hold.wipe && (!r_reg.full || hold.take);
  assign hold.load = src_valid && src_ready;
  assign hold.full = r_reg.full;
  assign hold.word = r_reg.word;

  always_comb begin
    r_next = r_reg;
    if (hold.take || hold.wipe) begin
      r_next.full = 1'b0;
      r_next.word = EPC_WORD_RST;
    end
    if (hold.load) begin
      r_next.full = 1'b1;
      r_next.word = src_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_reg <= '{full: 1'b0, word: EPC_WORD_RST};
    end else begin
      r_reg <= r_next;
    end
  end

  one_word_a: assert property (@(posedge clk_sys) disable iff (rst)
    hold.load |-> (!r_reg.full || hold.take))
    else $error("holder loaded over an unread word");
  fresh_take_a: assert property (@(posedge clk_sys) disable iff (rst)
    (hold.take && !hold.load) |=> !r_reg.full && (r_reg.word == EPC_WORD_RST))
    else $error("taken word still held");
endmodule
`default_nettype wire

// File: hdl/epc_poll_top.sv
// Entropy polling register: status, wipe-on-read word and access traps
// Assumes core access requests and noise source logic share clk_sys
// Function
// - Register sits in unprivileged space at address 0x015, 32 bits wide.
// - Status 31:30, reserved 29:24, custom 23:16, random value 15:0.
// - Codes: self-test 00, waiting 01, success 10, fatal 11.
// - Read-only access forms raise illegal instruction; only read-write serviced.
// - Written value is ignored; the write only signals a poll.
// - The 32-bit value is zero-extended to the integer register width.
// - Below machine mode, access traps unless explicitly granted.
// - Random bits read zero unless status is success; other fields zero.
// - Successful poll wipes the word and goes waiting unless another is ready.
// - Polls in waiting or fatal leave the state unchanged; in self-test a poll clears a pending alarm.
// - A non-fatal alarm holds self-test status until polled once.
// - Waiting status reports too little entropy; a normal condition.
// - Fatal status is permanent.
// - Self-test after reset or on alarm; normally waiting and success alternate.
// - Each delivered word is fresh and never delivered twice.
// - Initialization, test and alarms are visible through the status.
// - Grant bit 9 opens supervisor access, bit 8 user access.
// - Guest modes: granted read-write gives virtual trap, else illegal.
`timescale 1ns/1ps
`default_nettype none
module epc_poll_top
  import epc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Core access request
  input  wire logic        csr_req,
  input  wire logic [11:0] csr_addr,
  input  wire logic [1:0]  csr_op_kind,
  input  wire logic        csr_src_zero,
  input  wire logic [31:0] csr_wdata,
  input  wire logic [1:0]  priv_mode,
  input  wire logic        virt_mode,
  input  wire logic [31:0] sec_cfg,
  // Core access answer
  output logic             csr_ack,
  output logic [63:0]      csr_rdata,
  output logic             csr_illegal,
  output logic             csr_virt_trap,
  // Noise source
  input  wire logic        src_valid,
  input  wire logic [15:0] src_word,
  output logic             src_ready,
  input  wire logic        src_test_busy,
  input  wire logic        src_alarm,
  input  wire logic        src_fatal,
  // Status visibility
  output logic [1:0]       operational_status,
  output logic             alarm_pending
);
  localparam int SEC_SUPER_BIT = 9;
  localparam int SEC_USER_BIT  = 8;

  typedef struct packed {
    epc_state_type state;
    logic          alarm_pend;
    logic          ack;
    logic          ill;
    logic          virt;
    logic [31:0]   rdata;
  } epc_top_type;

  localparam epc_top_type EPC_TOP_RST = '{
    state:      EPC_ST_SELF_TEST,
    alarm_pend: 1'b0,
    ack:        1'b0,
    ill:        1'b0,
    virt:       1'b0,
    rdata:      EPC_RDATA_RST
  };

  epc_top_type r_reg;
  epc_top_type r_next;

  epc_word_if hold ();

  logic hit;
  logic allow;
  logic illegal;
  logic virt_trap;
  logic poll;

  // Status code of a state
  function automatic logic [1:0] status_code(input epc_state_type st);
    case (st)
      EPC_ST_SELF_TEST: status_code = EPC_CODE_TEST;
      EPC_ST_WAIT:      status_code = EPC_CODE_WAIT;
      EPC_ST_READY:     status_code = EPC_CODE_READY;
      EPC_ST_DEAD:      status_code = EPC_CODE_DEAD;
      default:          status_code = EPC_CODE_TEST;
    endcase
  endfunction

  // Register image; random bits only in success
  function automatic logic [31:0] pack_word(input logic [1:0] code, input logic [15:0] ent);
    pack_word = {code, EPC_RSVD_VAL, EPC_CUSTOM_VAL,
                 (code == EPC_CODE_READY) ? ent : EPC_WORD_RST};
  endfunction

  epc_access_check u_check (
    .priv_mode   (priv_mode),
    .virt_mode   (virt_mode),
    .op_kind     (csr_op_kind),
    .src_is_zero (csr_src_zero),
    .grant_super (sec_cfg[SEC_SUPER_BIT]),
    .grant_user  (sec_cfg[SEC_USER_BIT]),
    .allow       (allow),
    .illegal     (illegal),
    .virt_trap   (virt_trap)
  );

  epc_word_hold u_hold (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .src_valid (src_valid),
    .src_word  (src_word),
    .src_ready (src_ready),
    .hold      (hold.holder)
  );

  // Write data has no path into any state
  assign hit  = csr_req && (csr_addr == EPC_CSR_ADDR);
  assign poll = hit && allow;

  // Words are accepted only while the source is known healthy
  assign hold.enable = (r_reg.state == EPC_ST_WAIT) || (r_reg.state == EPC_ST_READY);

  always_comb begin
    r_next      = r_reg;
    r_next.ack  = hit;
    r_next.ill  = hit && illegal;
    r_next.virt = hit && virt_trap;
    r_next.rdata = EPC_RDATA_RST;
    hold.take   = 1'b0;
    hold.wipe   = 1'b0;
    if (poll) begin
      r_next.rdata = pack_word(status_code(r_reg.state), hold.word);
    end
    case (r_reg.state)
      EPC_ST_SELF_TEST: begin
        if (poll) begin
          r_next.alarm_pend = 1'b0;
        end
        if (!src_test_busy && !r_next.alarm_pend) begin
          r_next.state = EPC_ST_WAIT;
        end
      end
      EPC_ST_WAIT: begin
        // Polls here change nothing
        if (hold.full) begin
          r_next.state = EPC_ST_READY;
        end
      end
      EPC_ST_READY: begin
        if (poll) begin
          hold.take    = 1'b1;
          r_next.state = hold.load ? EPC_ST_READY : EPC_ST_WAIT;
        end
      end
      EPC_ST_DEAD: begin
        hold.wipe = 1'b1;
      end
      default: begin
        r_next.state = EPC_ST_SELF_TEST;
      end
    endcase
    // Fatal beats alarm; alarm set beats the poll clear
    if (src_fatal || (r_reg.state == EPC_ST_DEAD)) begin
      r_next.state = EPC_ST_DEAD;
      hold.wipe    = 1'b1;
      hold.take    = 1'b0;
    end else if (src_alarm) begin
      r_next.state      = EPC_ST_SELF_TEST;
      r_next.alarm_pend = 1'b1;
      hold.wipe         = 1'b1;
      hold.take         = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_reg <= EPC_TOP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign csr_ack            = r_reg.ack;
  assign csr_rdata          = {32'h00000000, r_reg.rdata};
  assign csr_illegal        = r_reg.ill;
  assign csr_virt_trap      = r_reg.virt;
  assign operational_status = status_code(r_reg.state);
  assign alarm_pending      = r_reg.alarm_pend;

  // Assertion helpers
  sequence s_ready_poll;
    poll && (r_reg.state == EPC_ST_READY) && !hold.load && !src_fatal && !src_alarm;
  endsequence

  sequence s_alarm_hold;
    (r_reg.state == EPC_ST_SELF_TEST) && r_reg.alarm_pend && !poll && !src_fatal;
  endsequence

  access_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
    hit |=> csr_ack && (csr_illegal || csr_virt_trap || !$past(illegal)))
    else $error("access to poll address not answered");

  read_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    (hit && csr_src_zero && (csr_op_kind != EPC_OP_RW)) |=> csr_illegal && (csr_rdata == 64'h0))
    else $error("read-only form not trapped");

  zero_extend_a: assert property (@(posedge clk_sys) disable iff (rst)
    csr_ack |-> (csr_rdata[63:32] == 32'h00000000))
    else $error("upper half not zero");

  entropy_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
    (csr_ack && (csr_rdata[EPC_ST_HI:EPC_ST_LO] != EPC_CODE_READY)) |->
      (csr_rdata[23:0] == 24'h000000))
    else $error("random bits outside success");

  user_grant_a: assert property (@(posedge clk_sys) disable iff (rst)
    (hit && !virt_mode && (priv_mode == EPC_PRIV_U) && !sec_cfg[SEC_USER_BIT]) |=>
      csr_illegal && !csr_virt_trap)
    else $error("ungranted user access not trapped");

  guest_trap_a: assert property (@(posedge clk_sys) disable iff (rst)
    (hit && virt_mode && (csr_op_kind == EPC_OP_RW) && sec_cfg[SEC_SUPER_BIT]) |=>
      csr_virt_trap && !csr_illegal)
    else $error("granted guest access not a virtual trap");

  poll_wipe_a: assert property (@(posedge clk_sys) disable iff (rst)
    s_ready_poll |=> (r_reg.state == EPC_ST_WAIT) && !hold.full &&
      (csr_rdata[EPC_ST_HI:EPC_ST_LO] == EPC_CODE_READY))
    else $error("poll did not wipe word");

  alarm_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    s_alarm_hold |=> (r_reg.state == EPC_ST_SELF_TEST) ||
      (r_reg.state == EPC_ST_DEAD))
    else $error("alarm left self-test unpolled");

  dead_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r_reg.state == EPC_ST_DEAD) |=> (r_reg.state == EPC_ST_DEAD)[*2])
    else $error("fatal state left");

  reset_test_a: assert property (@(posedge clk_sys)
    $past(rst) && !rst |-> (operational_status == EPC_CODE_TEST))
    else $error("not in self-test after reset");

  wait_stable_a: assert property (@(posedge clk_sys) disable iff (rst)
    ((r_reg.state == EPC_ST_WAIT) && !hold.full && !src_alarm && !src_fatal) |=>
      (r_reg.state == EPC_ST_WAIT))
    else $error("waiting state left without a word");

  ready_full_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r_reg.state == EPC_ST_READY) |-> hold.full)
    else $error("success without a held word");
endmodule
`default_nettype wire

// File: verif/epc_src_model.sv
// Behavioural noise source offering one 16-bit word at a time
// Assumes clk_sys from the bench; slow stretches the gaps between words
`timescale 1ns/1ps
`default_nettype none
module epc_src_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Pacing
  input  wire logic        slow,
  // Register side
  input  wire logic        src_ready,
  output logic             src_valid,
  output logic [15:0]      src_word
);
  int seed = 75;
  int gap;
  initial begin
    src_valid = 1'b0;
    src_word  = 16'h0000;
    forever begin
      // Gap of one or more cycles, so valid never drops and rises in one step
      gap = slow ? ($unsigned($random(seed)) % 20) + 1 : ($unsigned($random(seed)) % 3) + 1;
      repeat (gap) @(negedge clk_sys);
      src_valid = 1'b1;
      src_word  = $random(seed);
      do @(posedge clk_sys); while (!(src_ready && !rst));
      @(negedge clk_sys);
      src_valid = 1'b0;
      // Stale word inverted so nothing can read it as fresh
      src_word  = ~src_word;
    end
  end
endmodule
`default_nettype wire

// File: verif/entropy_poll_csr_test.sv
// Self-checking bench for the entropy polling register
// Assumes design inputs change at the falling edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module entropy_poll_csr_test;
  import epc_pkg::*;
  logic        clk_sys, rst, csr_req, csr_src_zero, virt_mode, slow;
  logic [11:0] csr_addr;
  logic [1:0]  csr_op_kind, priv_mode, operational_status;
  logic [31:0] csr_wdata, sec_cfg;
  logic        csr_ack, csr_illegal, csr_virt_trap, alarm_pending;
  logic [63:0] csr_rdata;
  logic        src_valid, src_ready, src_test_busy, src_alarm, src_fatal;
  logic [15:0] src_word;
  logic [15:0] q[$];
  int          seed = 75;
  int          miscompares = 0;
  int          checked = 0;

  epc_poll_top u_epc_poll_top (.clk_sys(clk_sys), .rst(rst), .csr_req(csr_req),
    .csr_addr(csr_addr), .csr_op_kind(csr_op_kind), .csr_src_zero(csr_src_zero),
    .csr_wdata(csr_wdata), .priv_mode(priv_mode), .virt_mode(virt_mode),
    .sec_cfg(sec_cfg), .csr_ack(csr_ack), .csr_rdata(csr_rdata),
    .csr_illegal(csr_illegal), .csr_virt_trap(csr_virt_trap), .src_valid(src_valid),
    .src_word(src_word), .src_ready(src_ready), .src_test_busy(src_test_busy),
    .src_alarm(src_alarm), .src_fatal(src_fatal),
    .operational_status(operational_status), .alarm_pending(alarm_pending));
  epc_src_model u_epc_src_model (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .src_ready(src_ready), .src_valid(src_valid), .src_word(src_word));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Words accepted but not yet polled; wiped with the holder
  always @(posedge clk_sys) begin
    if (rst || src_alarm || src_fatal) q.delete();
    else if (src_valid && src_ready) q.push_back(src_word);
  end

  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_code(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_code(input logic [1:0] code, input int n);
    int i;
    for (i = 0; i < n && operational_status !== code; i++) @(negedge clk_sys);
    cmp_code(operational_status, code);
    if (operational_status !== code) test_done();
  endtask

  // Expected trap flags {illegal, virtual}
  function automatic logic [1:0] exp_trap(input logic [1:0] pm, input logic vm,
      input logic [1:0] op, input logic z, input logic [31:0] cfg);
    logic rw;
    rw = (op == EPC_OP_RW) || ((op == EPC_OP_RS || op == EPC_OP_RC) && !z);
    if (vm) return (rw && cfg[9]) ? 2'b01 : 2'b10;
    if (!rw) return 2'b10;
    if (pm == EPC_PRIV_M) return 2'b00;
    if (pm == EPC_PRIV_S) return cfg[9] ? 2'b00 : 2'b10;
    return cfg[8] ? 2'b00 : 2'b10;
  endfunction

  task automatic access(input logic [1:0] pm, input logic vm, input logic [1:0] op,
      input logic z, input logic [31:0] cfg, input logic [11:0] ad);
    logic [1:0]  st, tr;
    logic        ld;
    logic [63:0] er;
    @(negedge clk_sys);
    {csr_req, csr_addr, priv_mode, virt_mode, csr_op_kind} = {1'b1, ad, pm, vm, op};
    {csr_src_zero, sec_cfg} = {z, cfg};
    // Write value is random noise and must not matter
    csr_wdata = $random(seed);
    #1 st = operational_status;
    ld = src_valid && src_ready;
    @(negedge clk_sys);
    csr_req = 1'b0;
    if (ad !== EPC_CSR_ADDR) begin
      cmp_code({1'b0, csr_ack}, 2'b00);
      return;
    end
    tr = exp_trap(pm, vm, op, z, cfg);
    er = 64'h0;
    if (tr == 2'b00) begin
      er[31:30] = st;
      if (st == EPC_CODE_READY) er[15:0] = q.size() > 0 ? q.pop_front() : 16'hxxxx;
    end
    cmp_code({1'b0, csr_ack}, 2'b01);
    cmp_code({csr_illegal, csr_virt_trap}, tr);
    cmp_data(csr_rdata, er);
    if (tr == 2'b00 && st == EPC_CODE_READY)
      cmp_code(operational_status, ld ? EPC_CODE_READY : EPC_CODE_WAIT);
    if (st == EPC_CODE_DEAD) cmp_code(operational_status, EPC_CODE_DEAD);
  endtask

  initial begin
    int i;
    logic [1:0] pm;
    {rst, csr_req, csr_src_zero, virt_mode, slow, src_alarm, src_fatal} = 7'b1000000;
    {csr_addr, csr_op_kind, priv_mode, csr_wdata, sec_cfg} = '0;
    src_test_busy = 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    cmp_code(operational_status, EPC_CODE_TEST);
    access(EPC_PRIV_M, 1'b0, EPC_OP_RW, 1'b1, 32'h0, EPC_CSR_ADDR);
    cmp_code(operational_status, EPC_CODE_TEST);
    src_test_busy = 1'b0;
    wait_code(EPC_CODE_WAIT, 20);
    for (i = 0; i < 400; i++) begin
      slow = (i / 100) % 2;
      pm = $random(seed);
      if (pm == 2'h2) pm = EPC_PRIV_M;
      if (i % 3 != 0) access(EPC_PRIV_M, 1'b0, EPC_OP_RW, $random(seed), 32'h0, EPC_CSR_ADDR);
      else access(pm, ($random(seed) % 4) == 0, ($unsigned($random(seed)) % 3) + 1,
        $random(seed), $random(seed), (i % 31 == 0) ? 12'h016 : EPC_CSR_ADDR);
    end
    // Non-fatal alarm stays latched until an allowed poll sees it
    @(negedge clk_sys);
    src_alarm = 1'b1;
    @(negedge clk_sys);
    src_alarm = 1'b0;
    repeat (5) @(negedge clk_sys);
    cmp_code(operational_status, EPC_CODE_TEST);
    access(EPC_PRIV_U, 1'b0, EPC_OP_RW, 1'b0, 32'h0, EPC_CSR_ADDR);
    cmp_code({1'b0, alarm_pending}, 2'b01);
    access(EPC_PRIV_M, 1'b0, EPC_OP_RW, 1'b0, 32'h0, EPC_CSR_ADDR);
    cmp_code({1'b0, alarm_pending}, 2'b00);
    wait_code(EPC_CODE_WAIT, 20);
    // Fatal failure is permanent until reset
    @(negedge clk_sys);
    src_fatal = 1'b1;
    @(negedge clk_sys);
    src_fatal = 1'b0;
    for (i = 0; i < 4; i++) access(EPC_PRIV_M, 1'b0, EPC_OP_RW, 1'b0, 32'h0, EPC_CSR_ADDR);
    repeat (10) @(negedge clk_sys);
    cmp_code(operational_status, EPC_CODE_DEAD);
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    cmp_code(operational_status, EPC_CODE_TEST);
    test_done();
  end
endmodule
`default_nettype wire
